/* File: common/perf_monitor_pkg.sv */
package perf_monitor_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int MAP_W = 16;
    localparam int NUM_TALLY = 7;

    localparam int IDX_CRC = 0;
    localparam int IDX_FER = 1;
    localparam int IDX_ALIGNMENT_CHANGE_TALLY = 2;
    localparam int IDX_OOF = 3;
    localparam int IDX_PAT = 4;
    localparam int IDX_LCV = 5;
    localparam int IDX_DDS = 6;

    localparam logic [ADDR_W-1:0] OFS_CRC_LO = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CRC_HI = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_FER_LO = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_FER_HI = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_ALIGNMENT_CHANGE_TALLY = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_OOF = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_PAT_LO = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_PAT_HI = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_LCV_LO = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_LCV_HI = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_DDS_LO = 4'hA;
    localparam logic [ADDR_W-1:0] OFS_DDS_HI = 4'hB;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'hC;

    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_REQ_BIT = 1;
    localparam int CTRL_FMT_LSB = 2;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [MAP_W-1:0] MAP_RESET = 16'h0000;

    typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC96} frame_format_e;

    localparam int CLK_PERIOD_NS = 20;
    localparam int SNAPSHOT_PERIOD_MS = 1000;
    localparam int SNAPSHOT_PERIOD_CYCLES = SNAPSHOT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    function automatic int tally_width(input int idx);
        case (idx)
            IDX_CRC: return 10;
            IDX_FER: return 12;
            IDX_ALIGNMENT_CHANGE_TALLY: return 3;
            IDX_OOF: return 5;
            IDX_DDS: return 10;
            default: return 16;
        endcase
    endfunction

    function automatic logic [MAP_W-1:0] tally_max(input int idx);
        return MAP_W'((33'd1 << tally_width(idx)) - 33'd1);
    endfunction
endpackage

/* File: src/sat_counter.sv */
`timescale 1ns/1ns
module sat_counter
    import perf_monitor_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Event and snapshot
    input wire logic inc,
    input wire logic snap,
    // Running tally
    output logic [WIDTH-1:0] count
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } state_s;

    state_s st;
    state_s next_st;

    if (WIDTH < 1 || WIDTH > MAP_W)
    begin : g_bad_width
        $error("sat_counter width out of range");
    end

    always_comb
    begin
        next_st = st;
        if (snap)
        begin
            next_st.count = WIDTH'(inc);
        end
        else if (inc && st.count != {WIDTH{1'b1}})
        begin
            next_st.count = st.count + WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign count = st.count;
endmodule

/* File: src/second_tick.sv */
`timescale 1ns/1ns
module second_tick
    import perf_monitor_pkg::*;
#(
    parameter int CYCLES = SNAPSHOT_PERIOD_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Run and pulse
    input wire logic enable,
    output logic tick
);
    localparam int CW = $clog2(CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } state_s;

    state_s st;
    state_s next_st;

    if (CYCLES < 2)
    begin : g_bad_cycles
        $error("second_tick needs at least two cycles");
    end

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!enable)
        begin
            next_st.cnt = '0;
        end
        else if (st.cnt == CW'(CYCLES - 1))
        begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule

/* File: src/perf_monitor.sv */
`timescale 1ns/1ns
module perf_monitor
    import perf_monitor_pkg::*;
#(
    parameter int SECOND_CYCLES = SNAPSHOT_PERIOD_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Event pulses from framer, checker and decoder
    input wire logic crc_error,
    input wire logic framing_bit_error,
    input wire logic alignment_change,
    input wire logic sync_loss,
    input wire logic pattern_error,
    input wire logic line_violation,
    input wire logic dds_pattern_error
);
    typedef struct packed {
        logic auto_snapshot_enable;
        logic snapshot_request;
        frame_format_e fmt;
        logic [NUM_TALLY-1:0][MAP_W-1:0] mapped;
        logic [DATA_W-1:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;
    logic [NUM_TALLY-1:0][MAP_W-1:0] cnt;
    logic [NUM_TALLY-1:0] inc;
    logic tick;
    logic ctrl_wr;
    logic req_rise;
    logic snap;

    assign ctrl_wr = wr && addr == OFS_CTRL;
    assign req_rise = ctrl_wr && wdata[CTRL_REQ_BIT] && !st.snapshot_request;
    assign snap = req_rise || (tick && st.auto_snapshot_enable);

    assign inc[IDX_CRC] = crc_error && st.fmt == FMT_ESF;
    assign inc[IDX_FER] = framing_bit_error;
    assign inc[IDX_ALIGNMENT_CHANGE_TALLY] = alignment_change;
    assign inc[IDX_OOF] = sync_loss;
    assign inc[IDX_PAT] = pattern_error;
    assign inc[IDX_LCV] = line_violation;
    assign inc[IDX_DDS] = dds_pattern_error && st.fmt == FMT_DM;

    second_tick #(
        .CYCLES(SECOND_CYCLES)
    ) u_second_tick (
        .mclk(mclk),
        .rst(rst),
        .enable(st.auto_snapshot_enable),
        .tick(tick)
    );

    for (genvar i = 0; i < NUM_TALLY; i++)
    begin : g_tally
        localparam int W = tally_width(i);
        logic [W-1:0] c;

        sat_counter #(
            .WIDTH(W)
        ) u_tally (
            .mclk(mclk),
            .rst(rst),
            .inc(inc[i]),
            .snap(snap),
            .count(c)
        );

        assign cnt[i] = MAP_W'(c);
    end

    always_comb
    begin
        next_st = st;
        next_st.rdata = '0;
        if (ctrl_wr)
        begin
            next_st.auto_snapshot_enable = wdata[CTRL_AUTO_BIT];
            next_st.snapshot_request = wdata[CTRL_REQ_BIT];
            next_st.fmt = frame_format_e'(wdata[CTRL_FMT_LSB +: 2]);
        end
        if (snap)
        begin
            next_st.mapped = cnt;
        end
        if (rd)
        begin
            case (addr)
                OFS_CRC_LO: next_st.rdata = st.mapped[IDX_CRC][7:0];
                OFS_CRC_HI: next_st.rdata = {2'h0, st.mapped[IDX_CRC][9:8], 4'h0};
                OFS_FER_LO: next_st.rdata = st.mapped[IDX_FER][7:0];
                OFS_FER_HI: next_st.rdata = {4'h0, st.mapped[IDX_FER][11:8]};
                OFS_ALIGNMENT_CHANGE_TALLY: next_st.rdata = {5'h00, st.mapped[IDX_ALIGNMENT_CHANGE_TALLY][2:0]};
                OFS_OOF: next_st.rdata = {3'h0, st.mapped[IDX_OOF][4:0]};
                OFS_PAT_LO: next_st.rdata = st.mapped[IDX_PAT][7:0];
                OFS_PAT_HI: next_st.rdata = st.mapped[IDX_PAT][15:8];
                OFS_LCV_LO: next_st.rdata = st.mapped[IDX_LCV][7:0];
                OFS_LCV_HI: next_st.rdata = st.mapped[IDX_LCV][15:8];
                OFS_DDS_LO: next_st.rdata = st.mapped[IDX_DDS][7:0];
                OFS_DDS_HI: next_st.rdata = {2'h0, st.mapped[IDX_DDS][9:8], 4'h0};
                OFS_CTRL: next_st.rdata = {4'h0, st.fmt, st.snapshot_request,
                    st.auto_snapshot_enable};
                default: next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st.auto_snapshot_enable <= CTRL_RESET[CTRL_AUTO_BIT];
            st.snapshot_request <= CTRL_RESET[CTRL_REQ_BIT];
            st.fmt <= FMT_SF;
            st.mapped <= {NUM_TALLY{MAP_RESET}};
            st.rdata <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;

    default clocking cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    sequence s_req_rise;
        ctrl_wr && wdata[CTRL_REQ_BIT] && !st.snapshot_request;
    endsequence

    sequence s_group_loaded;
        st.mapped == $past(cnt);
    endsequence

    sequence s_tallies_cleared;
        cnt == {NUM_TALLY{MAP_RESET}} || cnt == MAP_W'(0) || 1'b1;
    endsequence

    property p_req_rise;
        s_req_rise |=> s_group_loaded;
    endproperty
    a_req_rise: assert property (p_req_rise) else $error("group not loaded on request");

    property p_req_held;
        ctrl_wr && st.snapshot_request && !(tick && st.auto_snapshot_enable)
            |=> $stable(st.mapped);
    endproperty
    a_req_held: assert property (p_req_held) else $error("load without rising edge");

    property p_auto;
        tick && st.auto_snapshot_enable |=> s_group_loaded;
    endproperty
    a_auto: assert property (p_auto) else $error("periodic load missing");

    property p_crc_step;
        crc_error && st.fmt == FMT_ESF && !snap && cnt[IDX_CRC] < tally_max(IDX_CRC)
            |=> cnt[IDX_CRC] == $past(cnt[IDX_CRC]) + 16'd1;
    endproperty
    a_crc_step: assert property (p_crc_step) else $error("crc tally did not step");

    property p_crc_gated;
        st.fmt != FMT_ESF && !snap |=> cnt[IDX_CRC] == $past(cnt[IDX_CRC]);
    endproperty
    a_crc_gated: assert property (p_crc_gated) else $error("crc counted outside ESF");

    property p_fer_step;
        framing_bit_error && !snap && cnt[IDX_FER] < tally_max(IDX_FER)
            |=> cnt[IDX_FER] == $past(cnt[IDX_FER]) + 16'd1;
    endproperty
    a_fer_step: assert property (p_fer_step) else $error("framing tally did not step");

    property p_fer_esf;
        framing_bit_error && st.fmt == FMT_ESF && !snap && cnt[IDX_FER] == 16'd0
            |=> cnt[IDX_FER] == 16'd1;
    endproperty
    a_fer_esf: assert property (p_fer_esf) else $error("ESF alignment error lost");

    property p_alignment_change_tally_step;
        alignment_change && !snap && cnt[IDX_ALIGNMENT_CHANGE_TALLY] < tally_max(IDX_ALIGNMENT_CHANGE_TALLY)
            |=> cnt[IDX_ALIGNMENT_CHANGE_TALLY] == $past(cnt[IDX_ALIGNMENT_CHANGE_TALLY]) + 16'd1;
    endproperty
    a_alignment_change_tally_step: assert property (p_alignment_change_tally_step) else $error("alignment tally off");

    property p_oof_step;
        sync_loss && !snap && cnt[IDX_OOF] < tally_max(IDX_OOF)
            |=> cnt[IDX_OOF] == $past(cnt[IDX_OOF]) + 16'd1;
    endproperty
    a_oof_step: assert property (p_oof_step) else $error("sync loss tally off");

    property p_pat_read;
        rd && addr == OFS_PAT_HI |=> rdata == $past(st.mapped[IDX_PAT][15:8]);
    endproperty
    a_pat_read: assert property (p_pat_read) else $error("pattern high byte wrong");

    property p_lcv_step;
        line_violation && !snap && cnt[IDX_LCV] < tally_max(IDX_LCV)
            |=> cnt[IDX_LCV] == $past(cnt[IDX_LCV]) + 16'd1;
    endproperty
    a_lcv_step: assert property (p_lcv_step) else $error("line tally off");

    property p_dds_gated;
        st.fmt != FMT_DM && !snap |=> cnt[IDX_DDS] == $past(cnt[IDX_DDS]);
    endproperty
    a_dds_gated: assert property (p_dds_gated) else $error("DM tally counted outside DM");

    property p_dds_read;
        rd && addr == OFS_DDS_HI
            |=> rdata == {2'h0, $past(st.mapped[IDX_DDS][9:8]), 4'h0};
    endproperty
    a_dds_read: assert property (p_dds_read) else $error("DM high byte wrong");

    property p_clear;
        snap |=> cnt[IDX_PAT] == 16'($past(inc[IDX_PAT]));
    endproperty
    a_clear: assert property (p_clear) else $error("tally not cleared on load");

    property p_saturate;
        cnt[IDX_ALIGNMENT_CHANGE_TALLY] == tally_max(IDX_ALIGNMENT_CHANGE_TALLY) && !snap |=> cnt[IDX_ALIGNMENT_CHANGE_TALLY] == tally_max(IDX_ALIGNMENT_CHANGE_TALLY);
    endproperty
    a_saturate: assert property (p_saturate) else $error("tally wrapped");

    property p_hold;
        !snap |=> $stable(st.mapped);
    endproperty
    a_hold: assert property (p_hold) else $error("mapping changed between loads");

    property p_read_window;
        !rd |=> rdata == 8'h00;
    endproperty
    a_read_window: assert property (p_read_window) else $error("read data outside window");
endmodule

/* File: bench/event_source.sv */
`timescale 1ns/1ns
module event_source
(
    // Control from bench
    input wire logic [6:0] en,
    input wire logic dense,
    input wire logic [31:0] noise,
    // Event pulses
    output logic crc_error,
    output logic framing_bit_error,
    output logic alignment_change,
    output logic sync_loss,
    output logic pattern_error,
    output logic line_violation,
    output logic dds_pattern_error
);
    logic [6:0] fire;

    // Sparse random pulses, or a level held every cycle when dense
    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            fire[i] = en[i] && (dense || noise[4*i +: 2] == 2'h0);
        end
    end

    assign crc_error = fire[0];
    assign framing_bit_error = fire[1];
    assign alignment_change = fire[2];
    assign sync_loss = fire[3];
    assign pattern_error = fire[4];
    assign line_violation = fire[5];
    assign dds_pattern_error = fire[6];
endmodule

/* File: bench/test_perf_monitor.sv */
`timescale 1ns/1ns
module test_perf_monitor
    import perf_monitor_pkg::*;
;
    localparam int PER = 200;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [6:0] en = 7'h00;
    logic dense = 1'b0;
    logic [31:0] noise = 32'h0;
    logic [6:0] ev;
    int n_mismatch = 0;
    int comparisons = 0;
    int tally[7];
    int mapping[7];
    int wid[7] = '{10, 12, 3, 5, 16, 16, 10};
    logic [7:0] ctrl_m;

    always #10 mclk = ~mclk;
    always @(posedge mclk) noise <= $urandom();

    perf_monitor #(.SECOND_CYCLES(PER)) u_perf_monitor (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .crc_error(ev[0]),
        .framing_bit_error(ev[1]), .alignment_change(ev[2]), .sync_loss(ev[3]),
        .pattern_error(ev[4]), .line_violation(ev[5]), .dds_pattern_error(ev[6]));

    event_source u_event_source (.en(en), .dense(dense), .noise(noise), .crc_error(ev[0]),
        .framing_bit_error(ev[1]), .alignment_change(ev[2]), .sync_loss(ev[3]),
        .pattern_error(ev[4]), .line_violation(ev[5]), .dds_pattern_error(ev[6]));

    task automatic model_snap();
        mapping = tally;
        tally = '{default: 0};
    endtask

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tally = '{default: 0};
            mapping = '{default: 0};
            ctrl_m = 8'h00;
        end
        else
        begin
            if (wr && addr == OFS_CTRL && wdata[1] && !ctrl_m[1])
                model_snap();
            for (int i = 0; i < 7; i++)
            begin
                if (ev[i] && (i != 0 || ctrl_m[3:2] == 2'h1) && (i != 6 || ctrl_m[3:2] == 2'h2))
                    tally[i] = (tally[i] < (1 << wid[i]) - 1) ? tally[i] + 1 : tally[i];
            end
            if (wr && addr == OFS_CTRL)
                ctrl_m = wdata;
        end
    end

    function automatic logic [7:0] exp_byte(input int a);
        case (a)
            0: return 8'(mapping[0]);
            1: return {2'h0, 2'(mapping[0] >> 8), 4'h0};
            2: return 8'(mapping[1]);
            3: return {4'h0, 4'(mapping[1] >> 8)};
            4: return 8'(mapping[2]);
            5: return 8'(mapping[3]);
            6: return 8'(mapping[4]);
            7: return 8'(mapping[4] >> 8);
            8: return 8'(mapping[5]);
            9: return 8'(mapping[5] >> 8);
            10: return 8'(mapping[6]);
            11: return {2'h0, 2'(mapping[6] >> 8), 4'h0};
            12: return ctrl_m;
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_burst(input logic [3:0] a, input logic [7:0] d[$]);
        foreach (d[i])
        begin
            wr <= 1'b1;
            addr <= a;
            wdata <= d[i];
            @(posedge mclk);
        end
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic read_reg(input logic [3:0] a);
        logic [7:0] exp;
        exp = exp_byte(int'(a));
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), exp, rdata);
        @(posedge mclk);
        #1;
        check("idle rdata", 8'h00, rdata);
        @(posedge mclk);
    endtask

    task automatic check_all();
        for (int a = 0; a < 16; a++)
            read_reg(4'(a));
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("timeout");
        tally_and_finish();
    end

    initial
    begin
        logic [7:0] c;
        void'($urandom(32'hBFB3884B));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check_all();
        $display("test reset done");
        // Every format sparse, then DM and ESF held 1100 cycles, saturating the 3- and 5-bit tallies and that format's 10-bit tally
        for (int f = 0; f < 6; f++)
        begin
            c = (f < 4) ? 8'(f << 2) : ((f == 4) ? 8'h08 : 8'h04);
            en <= 7'h7F;
            dense <= (f >= 4);
            write_burst(OFS_CTRL, '{c});
            repeat ((f < 4) ? 150 : 1100) @(posedge mclk);
            write_burst(OFS_CTRL, '{c | 8'h02, c | 8'h02, c});
            check_all();
            check_all();
            $display("test format %0d done", f);
        end
        dense <= 1'b0;
        for (int a = 0; a < 16; a++)
            if (a != 12)
                write_burst(4'(a), '{8'($urandom())});
        check_all();
        $display("test read only done");
        repeat (30) @(posedge mclk);
        en <= 7'h00;
        write_burst(OFS_CTRL, '{8'h01});
        repeat (PER + 10) @(posedge mclk);
        model_snap();
        check_all();
        en <= 7'h7F;
        repeat (20) @(posedge mclk);
        en <= 7'h00;
        repeat (PER - 60) @(posedge mclk);
        model_snap();
        check_all();
        write_burst(OFS_CTRL, '{8'h00});
        $display("test auto done");
        en <= 7'h7F;
        repeat (20) @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check_all();
        write_burst(OFS_CTRL, '{8'h02, 8'h00});
        check_all();
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule
